// file: uer_pkg.sv
// Constants of the UART host register block, including its character bank decode.
// Assumes a 3-bit register address and an 8-bit host data path.
package uer_pkg;
    // Normal bank offsets
    localparam logic [2:0] A_DATA = 3'h0;
    localparam logic [2:0] A_IER  = 3'h1;
    localparam logic [2:0] A_ISR  = 3'h2;
    localparam logic [2:0] A_LCR  = 3'h3;
    localparam logic [2:0] A_MCR  = 3'h4;
    localparam logic [2:0] A_LSR  = 3'h5;
    localparam logic [2:0] A_MSR  = 3'h6;
    localparam logic [2:0] A_SPR  = 3'h7;
    // Divisor bank offsets
    localparam logic [2:0] A_DLL  = 3'h0;
    localparam logic [2:0] A_DLM  = 3'h1;
    localparam logic [2:0] A_DLD  = 3'h2;
    // Enhanced bank offsets
    localparam logic [2:0] A_FC   = 3'h0;
    localparam logic [2:0] A_FEATURE_CONTROL = 3'h1;
    localparam logic [2:0] A_EFR  = 3'h2;
    localparam int         A_CHAR_BIT = 2;
    // Bank select value and field positions
    localparam logic [7:0] LCR_ENH     = 8'hbf;
    localparam int         LCR_DIV_BIT = 7;
    localparam int         EFR_ENH_BIT = 4;
    localparam int         FCR_EN_BIT  = 0;
    localparam int         FCR_RXR_BIT = 1;
    localparam int         FCR_TXR_BIT = 2;
    localparam int         FEATURE_CONTROL_SEL_BIT = 7;
    localparam int         IE_RX = 0;
    localparam int         IE_TX = 1;
    localparam int         IE_LS = 2;
    localparam int         IE_MS = 3;
    // Masks of bits that need the enhanced enable, and of the base enable bits
    localparam logic [7:0] IER_ENH_MASK = 8'hf0;
    localparam logic [7:0] FCR_ENH_MASK = 8'h38;
    localparam logic [7:0] MCR_ENH_MASK = 8'he0;
    localparam logic [3:0] IER_BASE_MASK = 4'hf;
    // Interrupt status codes, bits 5..0
    localparam logic [5:0] ISR_LS   = 6'h06;
    localparam logic [5:0] ISR_TO   = 6'h0c;
    localparam logic [5:0] ISR_RX   = 6'h04;
    localparam logic [5:0] ISR_TX   = 6'h02;
    localparam logic [5:0] ISR_MS   = 6'h00;
    localparam logic [5:0] ISR_NONE = 6'h01;
    // Reset values
    localparam logic [7:0] ZERO8    = 8'h00;
    localparam logic [7:0] TRIGGER_LEVEL_VALUE_RST = 8'h01;
endpackage

// file: uer_char_bank.sv
// Small store for the four flow-control match characters.
// Assumes single-cycle write and read strobes on clk.
`timescale 1ns/100ps
`default_nettype none
module uer_char_bank #(
    parameter int DW = 8,
    parameter int AW = 2
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    // Storage write, no reset needed for data
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// file: uer_regs.sv
// Host register file and interrupt logic of a FIFO-buffered UART.
// Assumes FIFO, framing and modem logic on the same clk supply status.
`timescale 1ns/100ps
`default_nettype none
module uer_regs #(
    parameter int         LVL_W         = 7,
    parameter logic [7:0] REVISION_CODE = 8'h01, // Arbitrary value
    parameter logic [7:0] DEVICE_IDENT  = 8'h5a  // Arbitrary value
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             cs,
    input  wire logic             rd,
    input  wire logic             wr,
    input  wire logic [2:0]       addr,
    input  wire logic [7:0]       wdata,
    output logic      [7:0]       rdata,
    output logic                  irq,
    input  wire logic             rx_push,
    input  wire logic             rx_empty,
    input  wire logic [LVL_W-1:0] rx_level,
    input  wire logic [7:0]       rx_data,
    input  wire logic [2:0]       rx_head_err,
    input  wire logic             rx_err_in_fifo,
    input  wire logic             rx_overrun,
    input  wire logic             rx_timeout,
    input  wire logic             tx_empty,
    input  wire logic             tsr_empty,
    input  wire logic [LVL_W-1:0] tx_level,
    input  wire logic [7:0]       modem_status,
    output logic                  rx_pop,
    output logic                  tx_push,
    output logic      [7:0]       tx_data,
    output logic                  modem_status_rd,
    output logic                  rx_fifo_reset,
    output logic                  tx_fifo_reset,
    output logic                  fifo_enable,
    output logic      [7:0]       fifo_control,
    output logic      [7:0]       line_control,
    output logic      [7:0]       modem_control,
    output logic      [7:0]       divisor_low,
    output logic      [7:0]       divisor_high,
    output logic      [7:0]       divisor_fraction_mode,
    output logic      [7:0]       feature_control,
    output logic      [7:0]       enhanced_function,
    output logic      [7:0]       rx_trigger,
    output logic      [7:0]       tx_trigger
);
    logic [7:0] interrupt_enable;
    logic [7:0] scratch;
    logic [7:0] rdata_reg;
    logic       rd_char_q;
    logic [7:0] char_rdata;
    logic       bank_enh;
    logic       bank_div;
    logic       bank_norm;
    logic       enh_on;
    logic       div_zero;
    logic       dld_sel;
    logic       rd_cyc;
    logic       wr_cyc;
    logic       rhr_rd;
    logic       isr_rd;
    logic       lsr_rd;
    logic       thr_wr;
    logic       ier_wr;
    logic       fcr_wr;
    logic       char_wr;
    logic       char_rd;
    logic [7:0] rx_lvl8;
    logic [7:0] tx_lvl8;
    logic       rx_hit;
    logic       tx_cond;
    logic       tx_cond_q;
    logic       ier_tx_q;
    logic       tx_set;
    logic       tx_int;
    logic       to_flag;
    logic       ovr_flag;
    logic [2:0] head_err;
    logic       pend_ls;
    logic       pend_to;
    logic       pend_rx;
    logic       pend_tx;
    logic       pend_ms;
    logic [5:0] isr_code;
    logic [7:0] isr_val;
    logic [7:0] lsr_val;
    logic [7:0] next_rdata;

    // Bank decode from line control
    assign bank_enh  = (line_control == uer_pkg::LCR_ENH);
    assign bank_div  = line_control[uer_pkg::LCR_DIV_BIT] && !bank_enh;
    assign bank_norm = !line_control[uer_pkg::LCR_DIV_BIT];
    assign enh_on    = enhanced_function[uer_pkg::EFR_ENH_BIT];
    assign div_zero  = (divisor_low == uer_pkg::ZERO8) &&
                       (divisor_high == uer_pkg::ZERO8);
    // Fraction register hides status/FIFO control only when enhanced
    assign dld_sel   = bank_div && enh_on;

    // Access strobes and side-effect decode
    assign rd_cyc  = cs && rd;
    assign wr_cyc  = cs && wr;
    assign rhr_rd  = rd_cyc && bank_norm && addr == uer_pkg::A_DATA;
    assign isr_rd  = rd_cyc && !bank_enh && !dld_sel &&
                     addr == uer_pkg::A_ISR;
    assign lsr_rd  = rd_cyc && !bank_enh && addr == uer_pkg::A_LSR;
    assign thr_wr  = wr_cyc && bank_norm && addr == uer_pkg::A_DATA;
    assign ier_wr  = wr_cyc && bank_norm && addr == uer_pkg::A_IER;
    assign fcr_wr  = wr_cyc && !bank_enh && !dld_sel &&
                     addr == uer_pkg::A_ISR;
    assign char_wr = wr_cyc && bank_enh && addr[uer_pkg::A_CHAR_BIT];
    assign char_rd = rd_cyc && bank_enh && addr[uer_pkg::A_CHAR_BIT];

    // Handshake pulses to the FIFO and modem logic
    assign rx_pop          = rhr_rd;
    assign tx_push         = thr_wr;
    assign modem_status_rd = rd_cyc && !bank_enh && addr == uer_pkg::A_MSR;
    assign rx_fifo_reset   = fcr_wr && wdata[uer_pkg::FCR_EN_BIT] &&
                             wdata[uer_pkg::FCR_RXR_BIT];
    assign tx_fifo_reset   = fcr_wr && wdata[uer_pkg::FCR_EN_BIT] &&
                             wdata[uer_pkg::FCR_TXR_BIT];

    // Line control, reachable from every bank, and scratch, from all but the enhanced bank
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_control <= uer_pkg::ZERO8;
            scratch      <= uer_pkg::ZERO8;
        end else if (wr_cyc) begin
            if (addr == uer_pkg::A_LCR) begin
                line_control <= wdata;
            end
            if (!bank_enh && addr == uer_pkg::A_SPR) begin
                scratch <= wdata;
            end
        end
    end

    // Interrupt enable, upper bits need the enhanced enable
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            interrupt_enable <= uer_pkg::ZERO8;
        end else if (ier_wr) begin
            interrupt_enable <= enh_on ? wdata :
                (wdata & ~uer_pkg::IER_ENH_MASK) |
                (interrupt_enable & uer_pkg::IER_ENH_MASK);
        end
    end

    // FIFO control; other bits only take with the enable bit set
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fifo_enable  <= 1'b0;
            fifo_control <= uer_pkg::ZERO8;
        end else if (fcr_wr) begin
            fifo_enable <= wdata[uer_pkg::FCR_EN_BIT];
            if (wdata[uer_pkg::FCR_EN_BIT]) begin
                fifo_control <= enh_on ? wdata :
                    (wdata & ~uer_pkg::FCR_ENH_MASK) |
                    (fifo_control & uer_pkg::FCR_ENH_MASK);
            end
        end
    end

    // Modem control, upper bits need the enhanced enable
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            modem_control <= uer_pkg::ZERO8;
        end else if (wr_cyc && !bank_enh && addr == uer_pkg::A_MCR) begin
            modem_control <= enh_on ? wdata :
                (wdata & ~uer_pkg::MCR_ENH_MASK) |
                (modem_control & uer_pkg::MCR_ENH_MASK);
        end
    end

    // Divisor bank registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divisor_low           <= uer_pkg::ZERO8;
            divisor_high          <= uer_pkg::ZERO8;
            divisor_fraction_mode <= uer_pkg::ZERO8;
        end else if (wr_cyc && bank_div) begin
            if (addr == uer_pkg::A_DLL) begin
                divisor_low <= wdata;
            end
            if (addr == uer_pkg::A_DLM) begin
                divisor_high <= wdata;
            end
            if (addr == uer_pkg::A_DLD && enh_on) begin
                divisor_fraction_mode <= wdata;
            end
        end
    end

    // Enhanced bank registers and trigger level loading
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            feature_control   <= uer_pkg::ZERO8;
            enhanced_function <= uer_pkg::ZERO8;
            rx_trigger        <= uer_pkg::TRIGGER_LEVEL_VALUE_RST;
            tx_trigger        <= uer_pkg::TRIGGER_LEVEL_VALUE_RST;
        end else if (wr_cyc && bank_enh) begin
            if (addr == uer_pkg::A_FEATURE_CONTROL) begin
                feature_control <= wdata;
            end
            if (addr == uer_pkg::A_EFR) begin
                enhanced_function <= wdata;
            end
            if (addr == uer_pkg::A_FC) begin
                if (feature_control[uer_pkg::FEATURE_CONTROL_SEL_BIT]) begin
                    tx_trigger <= wdata;
                end else begin
                    rx_trigger <= wdata;
                end
            end
        end
    end

    // Transmit holding data
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_data <= uer_pkg::ZERO8;
        end else if (thr_wr) begin
            tx_data <= wdata;
        end
    end

    // Flow-control match characters
    uer_char_bank #(
        .DW(8),
        .AW(2)
    ) u_chars (
        .clk    (clk),
        .resetn (resetn),
        .we     (char_wr),
        .waddr  (addr[1:0]),
        .wdata  (wdata),
        .re     (char_rd),
        .raddr  (addr[1:0]),
        .rdata  (char_rdata)
    );

    // Levels widened for the trigger compare
    assign rx_lvl8 = 8'(rx_level);
    assign tx_lvl8 = 8'(tx_level);

    // Receive data condition, FIFO and non-FIFO mode
    assign rx_hit = fifo_enable ? (rx_lvl8 >= rx_trigger)
                                : !rx_empty;

    // Transmit ready condition, FIFO and non-FIFO mode
    assign tx_cond = fifo_enable ? (tx_lvl8 < tx_trigger)
                                 : tx_empty;

    // History of transmit condition and its enable
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_cond_q <= 1'b0;
            ier_tx_q  <= 1'b0;
        end else begin
            tx_cond_q <= tx_cond;
            ier_tx_q  <= interrupt_enable[uer_pkg::IE_TX];
        end
    end

    // Transmit ready event: condition arrives, or enable set while true
    assign tx_set = interrupt_enable[uer_pkg::IE_TX] && tx_cond &&
                    (!tx_cond_q || !ier_tx_q);

    // Sticky transmit ready; a new event beats the clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_int <= 1'b0;
        end else if (tx_set) begin
            tx_int <= 1'b1;
        end else if (isr_rd || thr_wr) begin
            tx_int <= 1'b0;
        end
    end

    // Sticky receive time-out, cleared by reading the holding register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            to_flag <= 1'b0;
        end else if (rx_timeout && fifo_enable) begin
            to_flag <= 1'b1;
        end else if (rhr_rd) begin
            to_flag <= 1'b0;
        end
    end

    // Sticky overrun, cleared by reading line status
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovr_flag <= 1'b0;
        end else if (rx_overrun) begin
            ovr_flag <= 1'b1;
        end else if (lsr_rd) begin
            ovr_flag <= 1'b0;
        end
    end

    // Error kind of the character at the head only
    assign head_err = rx_empty ? 3'h0 : rx_head_err;

    // Line status assembly
    assign lsr_val = {rx_err_in_fifo && fifo_enable,
                      tx_empty && tsr_empty,
                      tx_empty,
                      head_err,
                      ovr_flag,
                      !rx_empty || rx_push};

    // Enabled pending sources
    assign pend_ls = interrupt_enable[uer_pkg::IE_LS] &&
                     (ovr_flag || (|head_err));
    assign pend_to = interrupt_enable[uer_pkg::IE_RX] && to_flag;
    assign pend_rx = interrupt_enable[uer_pkg::IE_RX] && rx_hit;
    assign pend_tx = interrupt_enable[uer_pkg::IE_TX] && tx_int;
    assign pend_ms = interrupt_enable[uer_pkg::IE_MS] &&
                     (|modem_status[3:0]);

    // Interrupt output, nothing when all enables are clear
    assign irq = pend_ls || pend_to || pend_rx ||
                 pend_tx || pend_ms;

    // Priority encode of the highest pending source
    always_comb begin
        if (pend_ls) begin
            isr_code = uer_pkg::ISR_LS;
        end else if (pend_to) begin
            isr_code = uer_pkg::ISR_TO;
        end else if (pend_rx) begin
            isr_code = uer_pkg::ISR_RX;
        end else if (pend_tx) begin
            isr_code = uer_pkg::ISR_TX;
        end else if (pend_ms) begin
            isr_code = uer_pkg::ISR_MS;
        end else begin
            isr_code = uer_pkg::ISR_NONE;
        end
    end

    assign isr_val = {fifo_enable, fifo_enable, isr_code};

    // Read multiplexer over the three banks
    always_comb begin
        next_rdata = uer_pkg::ZERO8;
        if (addr == uer_pkg::A_LCR) begin
            next_rdata = line_control;
        end else if (bank_enh) begin
            case (addr)
                uer_pkg::A_FC: begin
                    next_rdata = feature_control[uer_pkg::FEATURE_CONTROL_SEL_BIT] ?
                                 tx_lvl8 : rx_lvl8;
                end
                uer_pkg::A_FEATURE_CONTROL: next_rdata = feature_control;
                uer_pkg::A_EFR:  next_rdata = enhanced_function;
                default:         next_rdata = uer_pkg::ZERO8;
            endcase
        end else begin
            case (addr)
                uer_pkg::A_DATA: begin
                    if (!bank_div) begin
                        next_rdata = rx_data;
                    end else if (div_zero) begin
                        next_rdata = REVISION_CODE;
                    end else begin
                        next_rdata = divisor_low;
                    end
                end
                uer_pkg::A_IER: begin
                    if (!bank_div) begin
                        next_rdata = enh_on ? interrupt_enable :
                            (interrupt_enable & ~uer_pkg::IER_ENH_MASK);
                    end else if (div_zero) begin
                        next_rdata = DEVICE_IDENT;
                    end else begin
                        next_rdata = divisor_high;
                    end
                end
                uer_pkg::A_ISR: begin
                    next_rdata = dld_sel ? divisor_fraction_mode : isr_val;
                end
                uer_pkg::A_MCR: next_rdata = modem_control;
                uer_pkg::A_LSR: next_rdata = lsr_val;
                uer_pkg::A_MSR: next_rdata = modem_status;
                uer_pkg::A_SPR: next_rdata = scratch;
                default:        next_rdata = uer_pkg::ZERO8;
            endcase
        end
    end

    // Read data capture
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= uer_pkg::ZERO8;
            rd_char_q <= 1'b0;
        end else if (rd_cyc) begin
            rdata_reg <= next_rdata;
            rd_char_q <= char_rd;
        end
    end

    assign rdata = rd_char_q ? char_rdata : rdata_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_rx_trigger_level_value;
        fifo_enable && interrupt_enable[uer_pkg::IE_RX] &&
        rx_lvl8 >= rx_trigger |-> irq;
    endproperty
    a_rx_trigger_level_value: assert property (p_rx_trigger_level_value)
        else $error("receive trigger reached without interrupt");

    property p_rx_drop;
        fifo_enable && rx_lvl8 < rx_trigger |-> isr_code != uer_pkg::ISR_RX;
    endproperty
    a_rx_drop: assert property (p_rx_drop)
        else $error("receive code shown below trigger");

    property p_dready;
        $rose(!rx_empty) || rx_push |-> lsr_val[0];
    endproperty
    a_dready: assert property (p_dready)
        else $error("data ready not set");

    property p_dclr;
        rx_empty && !rx_push |-> !lsr_val[0];
    endproperty
    a_dclr: assert property (p_dclr)
        else $error("data ready shown with receive side empty");

    property p_poll;
        interrupt_enable[3:0] == 4'h0 |-> !irq;
    endproperty
    a_poll: assert property (p_poll)
        else $error("interrupt in polled mode");

    property p_ovr;
        rx_overrun |=> ovr_flag ##0 lsr_val[1];
    endproperty
    a_ovr: assert property (p_ovr)
        else $error("overrun not flagged");

    property p_tsr;
        lsr_val[6] |-> lsr_val[5];
    endproperty
    a_tsr: assert property (p_tsr)
        else $error("shift empty shown with holding full");

    sequence s_tx_arm;
        !interrupt_enable[uer_pkg::IE_TX] ##1
        interrupt_enable[uer_pkg::IE_TX] && tx_cond;
    endsequence
    property p_tx_imm;
        s_tx_arm |=> tx_int;
    endproperty
    a_tx_imm: assert property (p_tx_imm)
        else $error("no immediate transmit interrupt");

    property p_tx_clr;
        (isr_rd || thr_wr) && !tx_set |=> !tx_int;
    endproperty
    a_tx_clr: assert property (p_tx_clr)
        else $error("transmit ready not cleared");

    property p_to_clr;
        rhr_rd && !(rx_timeout && fifo_enable) |=> !to_flag;
    endproperty
    a_to_clr: assert property (p_to_clr)
        else $error("time-out not cleared by holding read");

    property p_enh;
        ier_wr && !enh_on |=>
        interrupt_enable[7:4] == $past(interrupt_enable[7:4]);
    endproperty
    a_enh: assert property (p_enh)
        else $error("enhanced enable bits changed while locked");
endmodule
`default_nettype wire

// file: uer_host.sv
// Host model driving the register port.
// Assumes strobes are sampled on rising clk.
`timescale 1ns/100ps
`default_nettype none
module uer_host (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic            cs,
    output logic            rd,
    output logic            wr,
    output logic      [2:0] addr,
    output logic      [7:0] wdata
);
    // Idle bus
    initial {cs, rd, wr, addr, wdata} = '0;
    // Write strobe, then data inverted
    task automatic put(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        {cs, wr, addr, wdata} = {2'b11, a, d};
        @(negedge clk);
        {cs, wr, wdata} = {2'b00, ~d};
    endtask
    // Read strobe, data taken next cycle
    task automatic get(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk);
        {cs, rd, addr} = {2'b11, a};
        @(negedge clk);
        {cs, rd} = 2'b00;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// file: uer_regs_test.sv
// Bench for the UART register block.
// Assumes uer_regs and uer_host compiled first.
`timescale 1ns/100ps
`default_nettype none
module uer_regs_test;
    logic       clk = 1'b0;
    logic       resetn, irq, cs, rd, wr, rxe, ovr, tmo, efi, txe, tse, psh;
    logic [2:0] addr, herr;
    logic [3:0] ms;
    logic [6:0] lvl, tlv;
    logic [7:0] rdata, wdata, v;
    int         err_total = 0, samples_checked = 0;
    // Clock
    always #5 clk = ~clk;
    uer_host i_host (.clk(clk), .rdata(rdata), .cs(cs), .rd(rd), .wr(wr),
        .addr(addr), .wdata(wdata));
    uer_regs i_dut (.clk(clk), .resetn(resetn), .cs(cs), .rd(rd), .wr(wr),
        .addr(addr), .wdata(wdata), .rdata(rdata), .irq(irq), .rx_push(psh),
        .rx_empty(rxe), .rx_level(lvl), .rx_data(8'h3c), .rx_head_err(herr),
        .rx_err_in_fifo(efi), .rx_overrun(ovr), .rx_timeout(tmo),
        .tx_empty(txe), .tsr_empty(tse), .tx_level(tlv),
        .modem_status({4'h0, ms}), .rx_pop(), .tx_push(), .tx_data(),
        .modem_status_rd(), .rx_fifo_reset(), .tx_fifo_reset(),
        .fifo_enable(), .fifo_control(), .line_control(), .modem_control(),
        .divisor_low(), .divisor_high(), .divisor_fraction_mode(),
        .feature_control(), .enhanced_function(), .rx_trigger(),
        .tx_trigger());
    // Count a compare, report a mismatch
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Read and compare
    task automatic rc(input logic [2:0] a, input logic [7:0] exp);
        i_host.get(a, v);
        chk(v, exp);
    endtask
    // Counts, verdict, stop
    task automatic end_of_test;
        $display("checks %0d fails %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Cycle ceiling
    initial begin
        repeat (2000) @(posedge clk);
        err_total++;
        end_of_test();
    end
    // Status, interrupt and bank sequence
    initial begin
        {rxe, resetn, ovr, tmo, efi, txe, tse, herr, lvl} = 17'h10000;
        {psh, ms, tlv} = 12'h000;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        rc(3'h1, 8'h00);
        rc(3'h5, 8'h00);
        psh = 1'b1;
        rc(3'h5, 8'h01);
        psh = 1'b0;
        {rxe, herr, txe, ovr} = 6'b010111;
        @(negedge clk);
        ovr = 1'b0;
        rc(3'h5, 8'h37);
        i_host.put(3'h1, 8'h01);
        chk({7'h00, irq}, 8'h01);
        rc(3'h2, 8'h04);
        i_host.put(3'h2, 8'h01);
        lvl = 7'h01;
        rc(3'h2, 8'hc4);
        {lvl, rxe, tmo} = 9'h003;
        @(negedge clk);
        tmo = 1'b0;
        rc(3'h2, 8'hcc);
        rc(3'h0, 8'h3c);
        rc(3'h2, 8'hc1);
        i_host.put(3'h1, 8'h03);
        rc(3'h2, 8'hc2);
        rc(3'h2, 8'hc1);
        tlv = 7'h01;
        @(negedge clk);
        chk({7'h00, irq}, 8'h00);
        tlv = 7'h00;
        @(negedge clk);
        chk({7'h00, irq}, 8'h01);
        i_host.put(3'h0, 8'h55);
        rc(3'h2, 8'hc1);
        i_host.put(3'h1, 8'h00);
        {lvl, rxe, efi, herr, tse} = 13'h051;
        rc(3'h5, 8'he1);
        chk({7'h00, irq}, 8'h00);
        ms = 4'h1;
        i_host.put(3'h1, 8'h08);
        rc(3'h2, 8'hc0);
        chk({7'h00, irq}, 8'h01);
        ms = 4'h0;
        @(negedge clk);
        chk({7'h00, irq}, 8'h00);
        i_host.put(3'h1, 8'hf0);
        rc(3'h1, 8'h00);
        i_host.put(3'h3, 8'hbf);
        i_host.put(3'h2, 8'h10);
        i_host.put(3'h3, 8'h00);
        i_host.put(3'h1, 8'hf0);
        rc(3'h1, 8'hf0);
        i_host.put(3'h3, 8'h80);
        rc(3'h0, 8'h01);
        rc(3'h1, 8'h5a);
        i_host.put(3'h2, 8'h0e);
        rc(3'h2, 8'h0e);
        i_host.put(3'h3, 8'h00);
        rc(3'h2, 8'hc1);
        i_host.put(3'h3, 8'hbf);
        i_host.put(3'h4, 8'ha5);
        rc(3'h4, 8'ha5);
        $display("register test done");
        end_of_test();
    end
endmodule
`default_nettype wire
